// File: lmx_pkg.sv
package lmx_pkg;
  // timing, all times in ps
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PS = 25_000;
  localparam int unsigned T_SCAN_PS = 30_000_000;
  localparam int unsigned T_BLANK_PS = 800_000;
  localparam int unsigned T_STAG_PS = 270_000;
  localparam int unsigned SCAN_CYC = T_SCAN_PS / CLK_PS;
  // blanking is a least time, stagger a longest time
  localparam int unsigned BLANK_CYC = (T_BLANK_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned STAG_CYC = T_STAG_PS / CLK_PS;
  localparam int unsigned EDGE_CYC = BLANK_CYC + STAG_CYC;
  localparam int unsigned F55K_HZ = 55_000;
  localparam int unsigned F80K_HZ = 80_000;
  localparam int unsigned F4K_HZ = 4_000;
  localparam int unsigned F2K_HZ = 2_000;
  localparam int unsigned F1K_HZ = 1_000;
  localparam int unsigned F500_HZ = 500;
  localparam int unsigned F250_HZ = 250;
  localparam int unsigned SCAN_CYC_55K = CLK_HZ / F55K_HZ - EDGE_CYC;
  localparam int unsigned SCAN_CYC_80K = CLK_HZ / F80K_HZ - EDGE_CYC;
  // sizes
  localparam int unsigned DOTS = 143;
  localparam int unsigned SINKS = 16;
  localparam int unsigned ROWS = 9;
  localparam int unsigned FAULT_BYTES = 18;
  // register map
  localparam logic [7:0] ADR_DUTY_FIRST = 8'h01;
  localparam logic [7:0] ADR_DUTY_LAST = 8'h8F;
  localparam logic [7:0] ADR_SCALE_FIRST = 8'h90;
  localparam logic [7:0] ADR_SCALE_LAST = 8'h9F;
  localparam logic [7:0] ADR_CONFIG = 8'hA0;
  localparam logic [7:0] ADR_GLOBAL = 8'hA1;
  localparam logic [7:0] ADR_PULL = 8'hB0;
  localparam logic [7:0] ADR_SPREAD = 8'hB1;
  localparam logic [7:0] ADR_RATE = 8'hB2;
  localparam logic [7:0] ADR_FAULT_FIRST = 8'hB3;
  localparam logic [7:0] ADR_FAULT_LAST = 8'hC4;
  localparam logic [7:0] ADR_SOFT_RESET = 8'hCF;
  localparam logic [7:0] SOFT_RESET_KEY = 8'hAE;
  // reset values and masks
  localparam logic [7:0] CONFIG_RST = 8'h10;
  localparam logic [7:0] PULL_RST = 8'h33;
  localparam logic [2:0] RATE_RST = 3'h1;
  localparam logic [7:0] SPREAD_MASK = 8'h1F;
  localparam logic [6:0] GLOBAL_MAX = 7'h40;
  // config fields
  localparam int unsigned CFG_RUN = 0;
  localparam int unsigned CFG_FD_LSB = 1;
  localparam int unsigned CFG_LEVEL = 3;
  localparam int unsigned CFG_ROW_LSB = 4;
  localparam logic [1:0] FD_OFF = 2'h0;
  localparam logic [1:0] FD_SHORT = 2'h2;
  localparam logic [3:0] ROW_CODE_MAX16 = 4'h7;
  localparam logic [3:0] ROW_CODE_ALL_ON = 4'h8;
  localparam logic [3:0] ROWS_CODE_BASE = 4'h9;
  // bus address upper bits and byte length
  localparam logic [4:0] BUS_ADDR_HI = 5'h0D;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int unsigned DUTY_SHIFT = 8;
  localparam int unsigned GLOBAL_SHIFT = 6;

  typedef enum logic [2:0] {
    LMX_IDLE = 3'b000,
    LMX_ADDR = 3'b001,
    LMX_AACK = 3'b010,
    LMX_RECV = 3'b011,
    LMX_DACK = 3'b100,
    LMX_SEND = 3'b101,
    LMX_MACK = 3'b110,
    LMX_MNXT = 3'b111
  } lmx_i2c_t;

  typedef struct packed {
    logic [ROWS-1:0] rows;
    logic [SINKS-1:0] sinks;
  } lmx_pat_t;

  typedef struct packed {
    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic [1:0] strap_s1, strap_s2, strap;
    logic strap_done;
    logic [SINKS-1:0] sense_s1, sense_s2;
    lmx_i2c_t st;
    logic [3:0] bits;
    logic [7:0] shift, ptr;
    logic reading, got_reg, sda_drv;
    logic [DOTS-1:0][7:0] duty;
    logic [SINKS-1:0][7:0] scale;
    logic [7:0] cfg, pull, spread;
    logic [6:0] glob;
    logic [2:0] rate;
    logic [FAULT_BYTES-1:0][7:0] fault;
    logic [17:0] slot;
    logic [3:0] row, det_left;
    logic det_run;
    lmx_pat_t pat, xfer;
    logic [SINKS-1:0][7:0] peak;
    logic req, ack_s1, ack_s2;
  } lmx_sys_t;

  typedef struct packed {
    logic rst_s1, rst_s2, req_s1, req_s2, req_s3, ack;
    lmx_pat_t drive;
  } lmx_link_t;
endpackage

// File: lmx_led_matrix_register_bank.sv
`timescale 1ns/1ps
module lmx_led_matrix_register_bank #(
  parameter int unsigned SCAN_CYC_4K = lmx_pkg::CLK_HZ / lmx_pkg::F4K_HZ - lmx_pkg::EDGE_CYC,
  parameter int unsigned SCAN_CYC_2K = lmx_pkg::CLK_HZ / lmx_pkg::F2K_HZ - lmx_pkg::EDGE_CYC,
  parameter int unsigned SCAN_CYC_1K = lmx_pkg::CLK_HZ / lmx_pkg::F1K_HZ - lmx_pkg::EDGE_CYC,
  parameter int unsigned SCAN_CYC_500 = lmx_pkg::CLK_HZ / lmx_pkg::F500_HZ - lmx_pkg::EDGE_CYC,
  parameter int unsigned SCAN_CYC_250 = lmx_pkg::CLK_HZ / lmx_pkg::F250_HZ - lmx_pkg::EDGE_CYC
) (
  // clocks and reset
  input wire logic clk_sys_in,
  input wire logic clk_link_in,
  input wire logic reset_n_in,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic [1:0] addr_strap_in,
  // analog side
  input wire logic [lmx_pkg::SINKS-1:0] fault_sense_in,
  output logic soft_shutdown_n_out,
  output logic input_level_select_out,
  output logic [1:0] fault_test_out,
  output logic [7:0] pull_resistor_out,
  output logic [4:0] spread_spectrum_out,
  output logic [2:0] pwm_rate_code_out,
  output logic [lmx_pkg::SINKS-1:0][7:0] sink_peak_code_out,
  // matrix drive, link domain
  output logic [lmx_pkg::ROWS-1:0] row_source_out,
  output logic [lmx_pkg::SINKS-1:0] column_sink_out
);
  import lmx_pkg::*;

  lmx_sys_t r, n;
  lmx_link_t lr, ln;
  logic [7:0] rd_data;

  // readback mux; unmapped and write-only addresses read zero
  function automatic logic [7:0] rd_byte(input lmx_sys_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a >= ADR_DUTY_FIRST && a <= ADR_DUTY_LAST) begin
      v = s.duty[8'(a - ADR_DUTY_FIRST)];
    end else if (a >= ADR_SCALE_FIRST && a <= ADR_SCALE_LAST) begin
      v = s.scale[4'(a - ADR_SCALE_FIRST)];
    end else if (a >= ADR_FAULT_FIRST && a <= ADR_FAULT_LAST) begin
      v = s.fault[5'(a - ADR_FAULT_FIRST)];
    end else if (a == ADR_CONFIG) begin
      v = s.cfg;
    end else if (a == ADR_GLOBAL) begin
      v = {1'b0, s.glob};
    end else if (a == ADR_PULL) begin
      v = s.pull;
    end else if (a == ADR_SPREAD) begin
      v = s.spread;
    end else if (a == ADR_RATE) begin
      v = {5'h00, s.rate};
    end
    return v;
  endfunction

  assign rd_data = rd_byte(r, r.ptr);

  // whole system-domain next state
  always_comb begin
    logic scl_rise, scl_fall, start, stop, wr_en, all_on, arm;
    logic [7:0] wr_adr, wr_dat;
    logic [3:0] code, nrows;
    logic [4:0] nsinks;
    logic [17:0] scan_len, total, dly;
    logic [25:0] on_lim, pos;
    logic [7:0] idx;
    logic [6:0] glob_eff;
    logic [14:0] prod;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    wr_en = 1'b0;
    all_on = 1'b0;
    arm = 1'b0;
    wr_adr = 8'h00;
    wr_dat = 8'h00;
    code = 4'h0;
    nrows = 4'h0;
    nsinks = 5'h00;
    scan_len = 18'h00000;
    total = 18'h00000;
    dly = 18'h00000;
    on_lim = 26'h0000000;
    pos = 26'h0000000;
    idx = 8'h00;
    glob_eff = 7'h00;
    prod = 15'h0000;
    n = r;
    // pin synchronisers; stage 1 feeds only stage 2
    n.scl_s1 = scl_in;
    n.scl_s2 = r.scl_s1;
    n.scl_s3 = r.scl_s2;
    n.sda_s1 = sda_in;
    n.sda_s2 = r.sda_s1;
    n.sda_s3 = r.sda_s2;
    n.strap_s1 = addr_strap_in;
    n.strap_s2 = r.strap_s1;
    n.sense_s1 = fault_sense_in;
    n.sense_s2 = r.sense_s1;
    n.ack_s1 = lr.ack;
    n.ack_s2 = r.ack_s1;
    // strap is caught once after reset release, bus address is then fixed
    if (!r.strap_done) begin
      n.strap = r.strap_s2;
      n.strap_done = 1'b1;
    end
    scl_rise = r.scl_s2 & ~r.scl_s3;
    scl_fall = ~r.scl_s2 & r.scl_s3;
    start = r.scl_s2 & r.scl_s3 & r.sda_s3 & ~r.sda_s2;
    stop = r.scl_s2 & r.scl_s3 & ~r.sda_s3 & r.sda_s2;
    // byte framing; data sampled on rise, own drive changed on fall
    case (r.st)
      LMX_IDLE: begin
        n.sda_drv = 1'b0;
      end
      LMX_ADDR: begin
        if (scl_rise) begin
          n.shift = {r.shift[6:0], r.sda_s2};
          n.bits = r.bits + 4'h1;
        end else if (scl_fall && r.bits == BYTE_BITS) begin
          if (r.shift[7:1] == {BUS_ADDR_HI, r.strap}) begin
            n.st = LMX_AACK;
            n.sda_drv = 1'b1;
            n.reading = r.shift[0];
          end else begin
            n.st = LMX_IDLE;
          end
        end
      end
      LMX_AACK: begin
        if (scl_fall) begin
          n.bits = 4'h0;
          if (r.reading) begin
            n.st = LMX_SEND;
            n.shift = rd_data;
            n.sda_drv = ~rd_data[7];
            n.ptr = r.ptr + 8'h01;
          end else begin
            n.st = LMX_RECV;
            n.sda_drv = 1'b0;
            n.got_reg = 1'b0;
          end
        end
      end
      LMX_RECV: begin
        if (scl_rise) begin
          n.shift = {r.shift[6:0], r.sda_s2};
          n.bits = r.bits + 4'h1;
        end else if (scl_fall && r.bits == BYTE_BITS) begin
          n.st = LMX_DACK;
          n.sda_drv = 1'b1;
          if (!r.got_reg) begin
            n.ptr = r.shift;
            n.got_reg = 1'b1;
          end else begin
            wr_en = 1'b1;
            wr_adr = r.ptr;
            wr_dat = r.shift;
            n.ptr = r.ptr + 8'h01;
          end
        end
      end
      LMX_DACK: begin
        if (scl_fall) begin
          n.st = LMX_RECV;
          n.sda_drv = 1'b0;
          n.bits = 4'h0;
        end
      end
      LMX_SEND: begin
        if (scl_rise) begin
          n.bits = r.bits + 4'h1;
        end else if (scl_fall) begin
          if (r.bits == BYTE_BITS) begin
            n.st = LMX_MACK;
            n.sda_drv = 1'b0;
          end else begin
            n.shift = {r.shift[6:0], 1'b0};
            n.sda_drv = ~r.shift[6];
          end
        end
      end
      LMX_MACK: begin
        if (scl_rise) begin
          n.st = r.sda_s2 ? LMX_IDLE : LMX_MNXT;
        end
      end
      LMX_MNXT: begin
        if (scl_fall) begin
          n.st = LMX_SEND;
          n.bits = 4'h0;
          n.shift = rd_data;
          n.sda_drv = ~rd_data[7];
          n.ptr = r.ptr + 8'h01;
        end
      end
      default: begin
        n.st = LMX_IDLE;
      end
    endcase
    // start or repeated start always resynchronises, stop always frees the bus
    if (start) begin
      n.st = LMX_ADDR;
      n.bits = 4'h0;
      n.sda_drv = 1'b0;
    end else if (stop) begin
      n.st = LMX_IDLE;
      n.sda_drv = 1'b0;
    end
    // register writes; unmapped addresses fall through untouched
    if (wr_en) begin
      if (wr_adr >= ADR_DUTY_FIRST && wr_adr <= ADR_DUTY_LAST) begin
        n.duty[8'(wr_adr - ADR_DUTY_FIRST)] = wr_dat;
      end else if (wr_adr >= ADR_SCALE_FIRST && wr_adr <= ADR_SCALE_LAST) begin
        n.scale[4'(wr_adr - ADR_SCALE_FIRST)] = wr_dat;
      end else if (wr_adr >= ADR_FAULT_FIRST && wr_adr <= ADR_FAULT_LAST) begin
        n.fault[5'(wr_adr - ADR_FAULT_FIRST)] = wr_dat;
      end else if (wr_adr == ADR_CONFIG) begin
        n.cfg = wr_dat;
        // a test starts only on a move away from 00, so it runs once
        if (r.cfg[CFG_FD_LSB +: 2] == FD_OFF && wr_dat[CFG_FD_LSB +: 2] != FD_OFF) begin
          arm = 1'b1;
        end
      end else if (wr_adr == ADR_GLOBAL) begin
        n.glob = wr_dat[6:0];
      end else if (wr_adr == ADR_PULL) begin
        n.pull = wr_dat;
      end else if (wr_adr == ADR_SPREAD) begin
        n.spread = wr_dat & SPREAD_MASK;
      end else if (wr_adr == ADR_RATE) begin
        n.rate = wr_dat[2:0];
      end else if (wr_adr == ADR_SOFT_RESET && wr_dat == SOFT_RESET_KEY) begin
        n.duty = '0;
        n.scale = '0;
        n.fault = '0;
        n.cfg = CONFIG_RST;
        n.glob = 7'h00;
        n.pull = PULL_RST;
        n.spread = 8'h00;
        n.rate = RATE_RST;
        n.det_run = 1'b0;
      end
    end
    // row arrangement decode
    code = r.cfg[CFG_ROW_LSB +: 4];
    if (code != 4'h0 && code <= ROW_CODE_MAX16) begin
      nrows = ROWS_CODE_BASE - code;
      nsinks = 5'(SINKS);
    end else begin
      nrows = 4'(ROWS);
      nsinks = 5'(SINKS - 1);
    end
    all_on = (code == ROW_CODE_ALL_ON);
    // scan length per rate code
    case (r.rate)
      3'h0: scan_len = 18'(SCAN_CYC_55K);
      3'h1: scan_len = 18'(SCAN_CYC);
      3'h2: scan_len = 18'(SCAN_CYC_4K);
      3'h3: scan_len = 18'(SCAN_CYC_2K);
      3'h4: scan_len = 18'(SCAN_CYC_1K);
      3'h5: scan_len = 18'(SCAN_CYC_500);
      3'h6: scan_len = 18'(SCAN_CYC_250);
      default: scan_len = 18'(SCAN_CYC_80K);
    endcase
    total = scan_len + 18'(EDGE_CYC);
    // slot timing: stagger, scan, then blanking
    if (r.slot >= total - 18'h00001) begin
      n.slot = 18'h00000;
      n.row = (r.row + 4'h1 >= nrows) ? 4'h0 : r.row + 4'h1;
      // a key write in this cycle stops the test and keeps the cleared results
      if (r.det_run && n.det_run) begin
        n.fault[5'(2 * r.row)] = r.sense_s2[7:0];
        n.fault[5'(2 * r.row + 1)] = r.sense_s2[15:8];
        n.det_left = r.det_left + 4'h1;
        if (r.det_left + 4'h1 >= nrows) begin
          n.det_run = 1'b0;
        end
      end
    end else begin
      n.slot = r.slot + 18'h00001;
    end
    // a fresh trigger wins over the end of a running test in the same cycle
    if (arm) begin
      n.det_run = 1'b1;
      n.det_left = 4'h0;
    end
    // drive pattern; blanked and in shutdown everything is off
    n.pat = '0;
    if (r.cfg[CFG_RUN] && r.slot < 18'(STAG_CYC) + scan_len) begin
      n.pat.rows = all_on ? '1 : ROWS'(1) << r.row;
      for (int c = 0; c < SINKS; c++) begin
        dly = 18'((c * STAG_CYC) / SINKS);
        idx = 8'(r.row * SINKS + c);
        on_lim = 26'(r.duty[idx]) * 26'(scan_len);
        pos = 26'(r.slot - dly) << DUTY_SHIFT;
        if (5'(c) < nsinks && idx < 8'(DOTS) && r.slot >= dly && pos < on_lim) begin
          n.pat.sinks[c] = 1'b1;
        end
      end
    end
    // peak current codes
    glob_eff = (r.glob > GLOBAL_MAX) ? GLOBAL_MAX : r.glob;
    for (int c = 0; c < SINKS; c++) begin
      prod = 15'(glob_eff) * 15'(r.scale[c]);
      n.peak[c] = prod[GLOBAL_SHIFT +: 8];
    end
    // hand the pattern over once the previous one was taken
    if (r.req == r.ack_s2) begin
      n.xfer = r.pat;
      n.req = ~r.req;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      r <= '0;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_s3 <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_s3 <= 1'b1;
      // strap synchroniser keeps running so the first capture sees the pin
      r.strap_s1 <= n.strap_s1;
      r.strap_s2 <= n.strap_s2;
      r.cfg <= CONFIG_RST;
      r.pull <= PULL_RST;
      r.rate <= RATE_RST;
    end else begin
      r <= n;
    end
  end

  // link domain: take a stable pattern word on each request toggle
  always_comb begin
    ln = lr;
    ln.rst_s1 = reset_n_in;
    ln.rst_s2 = lr.rst_s1;
    ln.req_s1 = r.req;
    ln.req_s2 = lr.req_s1;
    ln.req_s3 = lr.req_s2;
    if (lr.req_s2 != lr.req_s3) begin
      ln.drive = r.xfer;
      ln.ack = lr.req_s2;
    end
  end

  always_ff @(posedge clk_link_in) begin
    if (!lr.rst_s2) begin
      lr <= '0;
      lr.rst_s1 <= ln.rst_s1;
      lr.rst_s2 <= ln.rst_s2;
    end else begin
      lr <= ln;
    end
  end

  // outputs straight from flops, except sda_out tied low, sda_oe_n_out inverted from sda_drv, and fault_test_out bit 0 decoded from the cfg test field
  assign sda_out = r.strap_done & 1'b0;
  assign sda_oe_n_out = ~r.sda_drv;
  assign soft_shutdown_n_out = r.cfg[CFG_RUN];
  assign input_level_select_out = r.cfg[CFG_LEVEL];
  assign fault_test_out = {r.det_run, r.cfg[CFG_FD_LSB +: 2] == FD_SHORT};
  assign pull_resistor_out = r.pull;
  assign spread_spectrum_out = r.spread[4:0];
  assign pwm_rate_code_out = r.rate;
  assign sink_peak_code_out = r.peak;
  assign row_source_out = lr.drive.rows;
  assign column_sink_out = lr.drive.sinks;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_data_byte_done;
    r.st == LMX_RECV && n.st == LMX_DACK && r.got_reg;
  endsequence
  sequence s_key_write;
    r.st == LMX_RECV && n.st == LMX_DACK && r.got_reg && r.ptr == ADR_SOFT_RESET
      && r.shift == SOFT_RESET_KEY;
  endsequence

  property p_ptr_step;
    s_data_byte_done |=> r.ptr == $past(r.ptr) + 8'h01;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");
  property p_soft_reset;
    s_key_write |=> r.cfg == CONFIG_RST && r.pull == PULL_RST && r.rate == RATE_RST;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("key write kept state");
  property p_reset_reads_zero;
    r.ptr == ADR_SOFT_RESET |-> rd_data == 8'h00;
  endproperty
  a_reset_reads_zero: assert property (p_reset_reads_zero) else $error("reset reg read");
  property p_shutdown_dark;
    !r.cfg[CFG_RUN] ##1 !r.cfg[CFG_RUN] |-> r.pat == '0;
  endproperty
  a_shutdown_dark: assert property (p_shutdown_dark) else $error("lit in shutdown");
  property p_blanking;
    r.slot >= 18'(STAG_CYC) + 18'(SCAN_CYC) && r.rate == RATE_RST |=> r.pat == '0;
  endproperty
  a_blanking: assert property (p_blanking) else $error("lit while blanking");
  property p_once;
    $rose(r.det_run) |-> $past(r.cfg[CFG_FD_LSB +: 2]) == FD_OFF;
  endproperty
  a_once: assert property (p_once) else $error("test started without rearm");
  property p_peak_sat;
    r.glob >= GLOBAL_MAX |=> r.peak[0] == $past(r.scale[0]) || $changed(r.scale[0]);
  endproperty
  a_peak_sat: assert property (p_peak_sat) else $error("global code not capped");
  property p_addr_ack;
    r.st == LMX_ADDR ##1 r.st == LMX_AACK |-> $past(r.shift[7:3]) == BUS_ADDR_HI;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("acked foreign address");
  property p_row_onehot;
    r.cfg[CFG_ROW_LSB +: 4] != ROW_CODE_ALL_ON ##1 r.cfg[CFG_ROW_LSB +: 4] != ROW_CODE_ALL_ON
      |-> $countones(r.pat.rows) <= 1;
  endproperty
  a_row_onehot: assert property (p_row_onehot) else $error("two rows on");
endmodule

// File: lmx_host.sv
`timescale 1ns/1ps
module lmx_host #(
  parameter logic [1:0] STRAP = 2'b10
) (
  // clock and device answer
  input wire logic clk_sys_in,
  input wire logic sda_oe_n_in,
  // bus lines seen by the device
  output logic scl_out,
  output logic sda_out
);
  logic pull_low;
  int nacks;
  // open drain with pull-up: a released line reads high, not its last value
  assign sda_out = ~(pull_low | ~sda_oe_n_in);
  initial begin
    scl_out = 1'b1;
    pull_low = 1'b0;
    nacks = 0;
  end
  // quarter bit of ten cycles keeps well clear of the pin synchronisers
  task automatic q();
    repeat (10) @(negedge clk_sys_in);
  endtask
  // start, or repeated start when scl is low
  task automatic start();
    pull_low = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    pull_low = 1'b1;
    q();
    scl_out = 1'b0;
    q();
  endtask
  task automatic stop();
    pull_low = 1'b1;
    q();
    scl_out = 1'b1;
    q();
    pull_low = 1'b0;
    q();
  endtask
  // data only moves while scl is low; sampled at the end of scl high
  task automatic bit_io(input logic b, output logic s);
    pull_low = ~b;
    q();
    scl_out = 1'b1;
    q();
    q();
    s = sda_out;
    scl_out = 1'b0;
    q();
  endtask
  task automatic send(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    if (s) begin
      nacks++;
    end
  endtask
  task automatic recv(output logic [7:0] d, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, s);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    start();
    send({lmx_pkg::BUS_ADDR_HI, STRAP, 1'b0});
    send(a);
    foreach (d[i]) send(d[i]);
    stop();
  endtask
  // pointer write, then repeated start with read direction
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] got[$]);
    logic [7:0] b;
    got = {};
    start();
    send({lmx_pkg::BUS_ADDR_HI, STRAP, 1'b0});
    send(a);
    start();
    send({lmx_pkg::BUS_ADDR_HI, STRAP, 1'b1});
    for (int i = 0; i < n; i++) begin
      recv(b, i == n - 1);
      got.push_back(b);
    end
    stop();
  endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb;
  import lmx_pkg::*;
  // stimulus and observed pins
  logic clk_sys_in = 1'b0;
  logic clk_link_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic scl, sda, sda_out, sda_oe_n_out, soft_shutdown_n_out, input_level_select_out;
  logic [1:0] fault_test_out;
  logic [7:0] pull_resistor_out;
  logic [4:0] spread_spectrum_out;
  logic [2:0] pwm_rate_code_out;
  logic [SINKS-1:0][7:0] sink_peak_code_out;
  logic [ROWS-1:0] row_source_out;
  logic [SINKS-1:0] column_sink_out;
  logic [7:0] got[$];
  logic [1:0] strap = 2'b10;
  logic [SINKS-1:0] sense = '0;
  int miscompares = 0;
  int compares = 0;
  // link clock is unrelated in phase to the system clock
  always #12.5 clk_sys_in = ~clk_sys_in;
  always #80 clk_link_in = ~clk_link_in;
  lmx_led_matrix_register_bank #(.SCAN_CYC_4K(200), .SCAN_CYC_2K(200), .SCAN_CYC_1K(200),
    .SCAN_CYC_500(200), .SCAN_CYC_250(200)) dut (
    .clk_sys_in(clk_sys_in), .clk_link_in(clk_link_in), .reset_n_in(reset_n_in),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .addr_strap_in(strap), .fault_sense_in(sense),
    .soft_shutdown_n_out(soft_shutdown_n_out), .input_level_select_out(input_level_select_out),
    .fault_test_out(fault_test_out), .pull_resistor_out(pull_resistor_out),
    .spread_spectrum_out(spread_spectrum_out), .pwm_rate_code_out(pwm_rate_code_out),
    .sink_peak_code_out(sink_peak_code_out), .row_source_out(row_source_out),
    .column_sink_out(column_sink_out));
  lmx_host host (.clk_sys_in(clk_sys_in), .sda_oe_n_in(sda_oe_n_out),
    .scl_out(scl), .sda_out(sda));
  // read a run of registers and compare each byte
  task automatic rdx(input logic [7:0] a, input logic [7:0] e[$]);
    host.rd(a, e.size(), got);
    foreach (e[i]) `CHK(got[i], e[i])
  endtask
  task automatic t_defaults();
    rdx(ADR_CONFIG, '{8'h10, 8'h00, 8'h00});
    rdx(ADR_PULL, '{8'h33, 8'h00, 8'h01});
    rdx(ADR_DUTY_LAST, '{8'h00, 8'h00});
    `CHK(soft_shutdown_n_out, 1'b0)
    `CHK(pwm_rate_code_out, 3'h1)
    `CHK(pull_resistor_out, 8'h33)
    `CHK(sda_out, 1'b0)
    $display("t_defaults done");
  endtask
  // burst crosses from the last duty byte into the scaling bytes
  task automatic t_burst();
    host.wr(ADR_DUTY_LAST, '{8'h11, 8'h22, 8'h33, 8'h44});
    rdx(ADR_DUTY_LAST, '{8'h11, 8'h22, 8'h33, 8'h44});
    host.wr(ADR_GLOBAL, '{8'h7F});
    rdx(ADR_GLOBAL, '{8'h7F});
    `CHK(sink_peak_code_out[0], 8'h22)
    host.wr(ADR_GLOBAL, '{8'h20});
    `CHK(sink_peak_code_out[1], 8'h19)
    $display("t_burst done");
  endtask
  task automatic t_config();
    int n;
    host.wr(ADR_CONFIG, '{8'h89});
    `CHK(soft_shutdown_n_out, 1'b1)
    `CHK(input_level_select_out, 1'b1)
    n = 0;
    while (row_source_out !== 9'h1FF && n < 3000) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK(row_source_out, 9'h1FF)
    if (n >= 3000) end_sim();
    host.wr(ADR_SPREAD, '{8'hFF, 8'h07});
    `CHK(spread_spectrum_out, 5'h1F)
    `CHK(pwm_rate_code_out, 3'h7)
    // dot 0 sits in row 0, sink 0; with all rows on only that sink may light while row 0 is scanned
    host.wr(ADR_DUTY_FIRST, '{8'hFF});
    n = 0;
    while (column_sink_out[0] !== 1'b1 && n < 6000) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK(column_sink_out, 16'h0001)
    `CHK(row_source_out, 9'h1FF)
    if (n >= 6000) end_sim();
    $display("t_config done");
  endtask
  // each test needs a return to the off code before it can run again
  task automatic t_fault();
    int n;
    sense = 16'hA55A;
    host.wr(ADR_CONFIG, '{8'h11});
    host.wr(ADR_CONFIG, '{8'h13});
    `CHK(fault_test_out, 2'b10)
    host.wr(ADR_CONFIG, '{8'h11});
    host.wr(ADR_CONFIG, '{8'h15});
    `CHK(fault_test_out, 2'b11)
    n = 0;
    while (fault_test_out[1] !== 1'b0 && n < 6000) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK(fault_test_out, 2'b01)
    if (n >= 6000) end_sim();
    rdx(ADR_FAULT_FIRST, '{8'h5A, 8'hA5});
    // eight rows scanned, so the ninth row's bytes stay clear
    rdx(ADR_FAULT_LAST - 8'h02, '{8'hA5, 8'h00, 8'h00});
    host.wr(ADR_CONFIG, '{8'h15});
    `CHK(fault_test_out, 2'b01)
    $display("t_fault done");
  endtask
  task automatic t_softrst();
    host.wr(ADR_SOFT_RESET, '{8'h55});
    rdx(ADR_RATE, '{8'h07, 8'h5A});
    rdx(ADR_SOFT_RESET, '{8'h00});
    host.wr(ADR_SOFT_RESET, '{SOFT_RESET_KEY});
    rdx(ADR_DUTY_LAST, '{8'h00, 8'h00});
    rdx(ADR_CONFIG, '{8'h10});
    rdx(ADR_RATE, '{8'h01, 8'h00});
    `CHK(pwm_rate_code_out, 3'h1)
    $display("t_softrst done");
  endtask
  // an address with the wrong strap bits gets no acknowledge
  task automatic t_addr();
    `CHK(host.nacks, 0)
    host.start();
    host.send(8'h6E);
    host.stop();
    `CHK(host.nacks, 1)
    $display("t_addr done");
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (95000) @(posedge clk_sys_in);
    miscompares++;
    end_sim();
  end
  // reset long enough for the link side as well, then the scenarios
  initial begin
    repeat (8) @(posedge clk_link_in);
    @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    t_defaults();
    t_burst();
    t_config();
    t_fault();
    t_softrst();
    t_addr();
    end_sim();
  end
endmodule
